/* File: dv/buck_fuse_model.sv */
// Host-side model holding the factory fuse levels and the channel-1 target register.
`timescale 1ns/1ps
`default_nettype none
module buck_fuse_model #(
   parameter logic [2:0] CH2_FUSE = 3'h5,
   parameter logic [2:0] CH3_FUSE = 3'h6,
   parameter logic [4:0] CH4_FUSE = 5'h1A
)
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [4:0] ch1Next,
   output logic [2:0] fuseCh2Code,
   output logic [2:0] fuseCh3Code,
   output logic [4:0] fuseCh4Code,
   output logic [4:0] ch1TargetCode
);
   assign fuseCh2Code = CH2_FUSE;
   assign fuseCh3Code = CH3_FUSE;
   assign fuseCh4Code = CH4_FUSE;
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         ch1TargetCode <= 5'h00;
      else
         ch1TargetCode <= ch1Next;
   end
endmodule
`default_nettype wire

/* File: dv/test_buck_voltage_select_regs.sv */
// Self-checking bench for the buck voltage selection register bank.
`timescale 1ns/1ps
`default_nettype none
module test_buck_voltage_select_regs;
   import buck_vsel_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [4:0] ch1Next = 5'h00;
   logic [7:0] regRdata;
   logic regRdataValid;
   logic [2:0] f2, f3, c2, c3;
   logic [4:0] f4, c4, t1, a1, a4;
   logic e1, e4;
   logic [1:0] i1, i4;
   logic [12:0] mv2, mv3, mv4;
   int error_cnt = 0;
   int cmp_count = 0;
   logic [4:0] c4Tab [8] = '{5'h00, 5'h01, 5'h02, 5'h06, 5'h10, 5'h1A, 5'h1E, 5'h1F};
   logic [12:0] mv4Tab [8] = '{13'd800, 13'd2500, 13'd2600, 13'd3000, 13'd4000, 13'd5000, 13'd5400, 13'd5500};
   always #20 ref_clk = ~ref_clk;
   buck_fuse_model FUSE (.ref_clk(ref_clk), .rstn(rstn), .ch1Next(ch1Next), .fuseCh2Code(f2),
      .fuseCh3Code(f3), .fuseCh4Code(f4), .ch1TargetCode(t1));
   buck_voltage_select_regs DUT (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .regRdataValid(regRdataValid),
      .fuseCh2Code(f2), .fuseCh3Code(f3), .fuseCh4Code(f4), .ch1TargetCode(t1), .ch2VoltageCode(c2),
      .ch3VoltageCode(c3), .ch4VoltageCode(c4), .ch1ScalingEnable(e1), .ch1ScalingInterval(i1),
      .ch4ScalingEnable(e4), .ch4ScalingInterval(i4), .ch1AppliedCode(a1), .ch4AppliedCode(a4),
      .ch2Mv(mv2), .ch3Mv(mv3), .ch4Mv(mv4));
   task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk) #1;
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(posedge ref_clk) #1;
      regWrite = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk) #1;
      regAddr = a;
      regRead = 1'b1;
      @(posedge ref_clk) #1;
      regRead = 1'b0;
      chk("valid", 13'(regRdataValid), 13'h1);
      chk("rdata", 13'(regRdata), 13'(exp));
      // The valid flag is a single-cycle pulse, so it must be gone one edge later.
      @(posedge ref_clk) #1;
      chk("validFall", 13'(regRdataValid), 13'h0);
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   function automatic logic [12:0] ch2Exp(input logic [2:0] c);
      if (c == 3'h0)
         return 13'd800;
      if (c == 3'h7)
         return 13'd5000;
      return 13'd3300 + 13'd300 * 13'(c - 3'h1);
   endfunction
   initial
   begin
      repeat (30000) @(posedge ref_clk);
      error_cnt++;
      tally_and_finish;
   end
   initial
   begin
      repeat (5) @(posedge ref_clk);
      #1 rstn = 1'b1;
      repeat (6) @(posedge ref_clk);
      rd(8'h03, {1'b0, 3'h6, 1'b0, 3'h5});
      rd(8'h04, 8'h1A);
      rd(8'h05, 8'h00);
      chk("intervals", 13'({i4, i1}), 13'h0);
      $display("Test reset defaults done");
      for (int c = 0; c < 8; c++)
      begin
         wr(8'h03, {1'b1, 3'(c), 1'b1, 3'(c)});
         @(posedge ref_clk) #1;
         chk("ch3Mv", mv3, (c == 0) ? 13'd800 : 13'd1100 + 13'd100 * 13'(c));
         chk("ch2Mv", mv2, (c == 6) ? 13'd4800 : ch2Exp(3'(c)));
         chk("ch3Code", 13'(c3), 13'(c));
         chk("ch2Code", 13'(c2), 13'(c));
         rd(8'h03, {1'b1, 3'(c), 1'b1, 3'(c)});
      end
      $display("Test channel 2 and 3 maps done");
      for (int k = 0; k < 8; k++)
      begin
         wr(8'h04, {3'h7, c4Tab[k]});
         chk("ch4Code", 13'(c4), 13'(c4Tab[k]));
         // The applied code trails the field by one cycle and the millivolt output by one more.
         repeat (2) @(posedge ref_clk);
         #1;
         chk("ch4Mv", mv4, mv4Tab[k]);
         rd(8'h04, {3'h7, c4Tab[k]});
      end
      $display("Test channel 4 map done");
      for (int m = 0; m < 4; m++)
      begin
         wr(8'h05, {1'b1, 1'b1, 2'(m), 1'b1, 1'b0, 2'(3 - m)});
         chk("cfg", 13'({e4, i4, e1, i1}), 13'({1'b1, 2'(m), 1'b0, 2'(3 - m)}));
      end
      wr(8'h10, 8'h55);
      rd(8'h10, 8'h00);
      rd(8'h05, 8'hF8);
      $display("Test config and unmapped done");
      wr(8'h05, 8'h00);
      wr(8'h04, 8'h05);
      wr(8'h05, 8'h77);
      wr(8'h04, 8'h07);
      ch1Next = 5'h03;
      repeat (150) @(posedge ref_clk);
      #1;
      chk("ch4Applied", 13'(a4), 13'h5);
      chk("ch1Applied", 13'(a1), 13'h0);
      repeat (100) @(posedge ref_clk);
      #1;
      chk("ch4Applied", 13'(a4), 13'h6);
      chk("ch1Applied", 13'(a1), 13'h1);
      repeat (400) @(posedge ref_clk);
      #1;
      chk("ch4Applied", 13'(a4), 13'h7);
      chk("ch1Applied", 13'(a1), 13'h3);
      $display("Test scaling ramp done");
      tally_and_finish;
   end
endmodule
`default_nettype wire

/* File: src/buck_voltage_select_regs.sv */
// Voltage selection registers for buck channels 2 to 4 and scaling configuration registers for channels 1 and 4.
`timescale 1ns/1ps
`default_nettype none
module buck_voltage_select_regs
   import buck_vsel_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   output logic regRdataValid,
   input wire logic [2:0] fuseCh2Code,
   input wire logic [2:0] fuseCh3Code,
   input wire logic [4:0] fuseCh4Code,
   input wire logic [4:0] ch1TargetCode,
   output logic [2:0] ch2VoltageCode,
   output logic [2:0] ch3VoltageCode,
   output logic [4:0] ch4VoltageCode,
   output logic ch1ScalingEnable,
   output logic [1:0] ch1ScalingInterval,
   output logic ch4ScalingEnable,
   output logic [1:0] ch4ScalingInterval,
   output logic [4:0] ch1AppliedCode,
   output logic [4:0] ch4AppliedCode,
   output logic [12:0] ch2Mv,
   output logic [12:0] ch3Mv,
   output logic [12:0] ch4Mv
);

   function automatic tick_t stepCycles(input logic [1:0] iv);
      case (iv)
         2'b00: return STEP0_CYC;
         2'b01: return STEP1_CYC;
         2'b10: return STEP2_CYC;
         default: return STEP3_CYC;
      endcase
   endfunction

   function automatic mv_t ch3ToMv(input logic [2:0] c);
      if (c == 3'b000)
      begin
         return ADJ_MV;
      end
      return mv_t'(CH3_BASE_MV + CH3_STEP_MV * mv_t'(c));
   endfunction

   function automatic mv_t ch2ToMv(input logic [2:0] c);
      if (c == 3'b000)
      begin
         return ADJ_MV;
      end
      else if (c == CH2_TOP_CODE)
      begin
         return CH2_TOP_MV;
      end
      else if (c == CH2_GAP_CODE)
      begin
         return CH2_GAP_MV;
      end
      return mv_t'(CH2_BASE_MV + CH2_STEP_MV * (mv_t'(c) - mv_t'(1)));
   endfunction

   function automatic mv_t ch4ToMv(input logic [4:0] c);
      if (c == 5'b00000)
      begin
         return ADJ_MV;
      end
      return mv_t'(CH4_BASE_MV + CH4_STEP_MV * mv_t'(c));
   endfunction

   init_state_t state_r, state_nxt;
   logic [10:0] fuseS1_r, fuseS1_nxt;
   logic [10:0] fuseS2_r, fuseS2_nxt;
   logic [7:0] ch23_r, ch23_nxt;
   logic [7:0] ch4Reg_r, ch4Reg_nxt;
   logic [7:0] cfg_r, cfg_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [4:0] applied_r [2];
   logic [4:0] applied_nxt [2];
   tick_t timer_r [2];
   tick_t timer_nxt [2];
   mv_t ch2Mv_r, ch2Mv_nxt;
   mv_t ch3Mv_r, ch3Mv_nxt;
   mv_t ch4Mv_r, ch4Mv_nxt;
   logic [4:0] tgt [2];
   logic en [2];
   logic [1:0] iv [2];

   assign tgt[0] = ch1TargetCode;
   assign tgt[1] = ch4Reg_r[CH4_LSB +: 5];
   assign en[0] = cfg_r[CH1_EN_BIT];
   assign en[1] = cfg_r[CH4_EN_BIT];
   assign iv[0] = cfg_r[CH1_INT_LSB +: 2];
   assign iv[1] = cfg_r[CH4_INT_LSB +: 2];

   always_comb
   begin
      state_nxt = state_r;
      fuseS1_nxt = {fuseCh4Code, fuseCh3Code, fuseCh2Code};
      fuseS2_nxt = fuseS1_r;
      ch23_nxt = ch23_r;
      ch4Reg_nxt = ch4Reg_r;
      cfg_nxt = cfg_r;
      rdata_nxt = rdata_r;
      rvalid_nxt = 1'b0;
      // Fuse levels come from outside the clock domain, so they are loaded only after two flops.
      case (state_r)
         ST_SYNC: state_nxt = ST_SETTLE;
         ST_SETTLE: state_nxt = ST_LOAD;
         ST_LOAD:
         begin
            ch23_nxt = {1'b0, fuseS2_r[5:3], 1'b0, fuseS2_r[2:0]};
            ch4Reg_nxt = {3'b000, fuseS2_r[10:6]};
            state_nxt = ST_RUN;
         end
         ST_RUN:
         begin
            if (regWrite)
            begin
               if (regAddr == CH23_SEL_ADDR)
               begin
                  ch23_nxt = regWdata;
               end
               else if (regAddr == CH4_SEL_ADDR)
               begin
                  ch4Reg_nxt = regWdata;
               end
               else if (regAddr == SCALE_CFG_ADDR)
               begin
                  cfg_nxt = regWdata;
               end
            end
         end
         default: state_nxt = ST_SYNC;
      endcase
      if (regRead)
      begin
         rvalid_nxt = 1'b1;
         if (regAddr == CH23_SEL_ADDR)
         begin
            rdata_nxt = ch23_r;
         end
         else if (regAddr == CH4_SEL_ADDR)
         begin
            rdata_nxt = ch4Reg_r;
         end
         else if (regAddr == SCALE_CFG_ADDR)
         begin
            rdata_nxt = cfg_r;
         end
         else
         begin
            rdata_nxt = READ_UNMAPPED;
         end
      end
      for (int i = 0; i < 2; i++)
      begin
         applied_nxt[i] = applied_r[i];
         timer_nxt[i] = timer_r[i];
         if (!en[i])
         begin
            applied_nxt[i] = tgt[i];
            timer_nxt[i] = TICK_RESET;
         end
         else if (applied_r[i] != tgt[i])
         begin
            if (timer_r[i] >= stepCycles(iv[i]) - tick_t'(1))
            begin
               timer_nxt[i] = TICK_RESET;
               if (applied_r[i] < tgt[i])
               begin
                  applied_nxt[i] = applied_r[i] + 5'd1;
               end
               else
               begin
                  applied_nxt[i] = applied_r[i] - 5'd1;
               end
            end
            else
            begin
               timer_nxt[i] = timer_r[i] + tick_t'(1);
            end
         end
         else
         begin
            timer_nxt[i] = TICK_RESET;
         end
      end
      ch2Mv_nxt = ch2ToMv(ch23_r[CH2_LSB +: 3]);
      ch3Mv_nxt = ch3ToMv(ch23_r[CH3_LSB +: 3]);
      ch4Mv_nxt = ch4ToMv(applied_r[1]);
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= ST_SYNC;
         fuseS1_r <= FUSE_RESET;
         fuseS2_r <= FUSE_RESET;
         ch23_r <= CH23_SEL_RESET;
         ch4Reg_r <= CH4_SEL_RESET;
         cfg_r <= SCALE_CFG_RESET;
         rdata_r <= READ_UNMAPPED;
         rvalid_r <= 1'b0;
         applied_r[0] <= APPLIED_RESET;
         applied_r[1] <= APPLIED_RESET;
         timer_r[0] <= TICK_RESET;
         timer_r[1] <= TICK_RESET;
         ch2Mv_r <= MV_RESET;
         ch3Mv_r <= MV_RESET;
         ch4Mv_r <= MV_RESET;
      end
      else
      begin
         state_r <= state_nxt;
         fuseS1_r <= fuseS1_nxt;
         fuseS2_r <= fuseS2_nxt;
         ch23_r <= ch23_nxt;
         ch4Reg_r <= ch4Reg_nxt;
         cfg_r <= cfg_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         applied_r[0] <= applied_nxt[0];
         applied_r[1] <= applied_nxt[1];
         timer_r[0] <= timer_nxt[0];
         timer_r[1] <= timer_nxt[1];
         ch2Mv_r <= ch2Mv_nxt;
         ch3Mv_r <= ch3Mv_nxt;
         ch4Mv_r <= ch4Mv_nxt;
      end
   end

   assign regRdata = rdata_r;
   assign regRdataValid = rvalid_r;
   assign ch2VoltageCode = ch23_r[CH2_LSB +: 3];
   assign ch3VoltageCode = ch23_r[CH3_LSB +: 3];
   assign ch4VoltageCode = ch4Reg_r[CH4_LSB +: 5];
   assign ch1ScalingEnable = cfg_r[CH1_EN_BIT];
   assign ch1ScalingInterval = cfg_r[CH1_INT_LSB +: 2];
   assign ch4ScalingEnable = cfg_r[CH4_EN_BIT];
   assign ch4ScalingInterval = cfg_r[CH4_INT_LSB +: 2];
   assign ch1AppliedCode = applied_r[0];
   assign ch4AppliedCode = applied_r[1];
   assign ch2Mv = ch2Mv_r;
   assign ch3Mv = ch3Mv_r;
   assign ch4Mv = ch4Mv_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence s_runWrite(logic [7:0] a);
      state_r == ST_RUN && regWrite && regAddr == a;
   endsequence

   sequence s_ch4Stepping;
      ch4ScalingEnable && ch4AppliedCode != ch4VoltageCode;
   endsequence

   a_ch3_field_write: assert property (s_runWrite(CH23_SEL_ADDR) |=>
      ch3VoltageCode == 3'(($past(regWdata) >> CH3_LSB) & 8'h07))
      else $error("channel-3 code did not take the written value");
   a_ch3_top_map: assert property (ch3VoltageCode == 3'b111 ##1 ch3VoltageCode == 3'b111 |-> ch3Mv == 13'd1800)
      else $error("channel-3 code 111 not mapped to 1.8 V");
   a_ch3_gap_map: assert property (ch3VoltageCode == 3'b110 |=> ch3Mv == 13'd1700)
      else $error("channel-3 code 110 not mapped to 1.7 V");
   a_ch2_field_write: assert property (s_runWrite(CH23_SEL_ADDR) |=>
      ch2VoltageCode == 3'($past(regWdata) & 8'h07))
      else $error("channel-2 code did not take the written value");
   a_ch2_low_map: assert property (ch2VoltageCode == 3'b001 |=> ch2Mv == 13'd3300)
      else $error("channel-2 code 001 not mapped to 3.3 V");
   a_ch4_field_write: assert property (s_runWrite(CH4_SEL_ADDR) |=>
      {3'b000, ch4VoltageCode} == ($past(regWdata) & 8'h1F))
      else $error("channel-4 code did not take the written value");
   a_ch4_volt_map: assert property (ch4AppliedCode == 5'b11010 |=> ch4Mv == 13'd5000)
      else $error("channel-4 code 11010 not mapped to 5.0 V");
   a_ch4_enable_reset: assert property (state_r == ST_LOAD |-> !ch4ScalingEnable ##1 ch4ScalingInterval == 2'b00)
      else $error("channel-4 scaling not disabled after reset");
   a_ch4_step_time: assert property (ch4ScalingEnable && ch4ScalingInterval == 2'b11 &&
      $changed(ch4AppliedCode) && $past(ch4ScalingEnable) ##1 s_ch4Stepping [*8] |-> $stable(ch4AppliedCode))
      else $error("channel-4 stepped before its interval ran out");
   a_ch1_enable_reset: assert property (state_r == ST_LOAD |-> !ch1ScalingEnable)
      else $error("channel-1 scaling not disabled after reset");
   a_ch1_step_time: assert property (ch1ScalingEnable && $past(ch1ScalingEnable) &&
      $changed(ch1AppliedCode) |-> $past(timer_r[0]) >= stepCycles($past(ch1ScalingInterval)) - tick_t'(1))
      else $error("channel-1 stepped before its interval ran out");
   a_ch4_single_step: assert property (s_ch4Stepping |=>
      ch4AppliedCode == $past(ch4AppliedCode) || ch4AppliedCode == $past(ch4AppliedCode) + 5'd1 ||
      ch4AppliedCode == $past(ch4AppliedCode) - 5'd1)
      else $error("channel-4 applied code jumped more than one step");
endmodule
`default_nettype wire

/* File: src/buck_vsel_pkg.sv */
// Constants and types shared by the buck voltage selection register bank.
package buck_vsel_pkg;
   localparam logic [7:0] CH23_SEL_ADDR = 8'h03;
   localparam logic [7:0] CH4_SEL_ADDR = 8'h04;
   localparam logic [7:0] SCALE_CFG_ADDR = 8'h05;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam int CH3_LSB = 4;
   localparam int CH2_LSB = 0;
   localparam int CH4_LSB = 0;
   localparam int CH4_EN_BIT = 6;
   localparam int CH4_INT_LSB = 4;
   localparam int CH1_EN_BIT = 2;
   localparam int CH1_INT_LSB = 0;
   localparam logic [7:0] CH23_SEL_RESET = 8'h00;
   localparam logic [7:0] CH4_SEL_RESET = 8'h00;
   localparam logic [7:0] SCALE_CFG_RESET = 8'h00;
   localparam logic [4:0] APPLIED_RESET = 5'h00;
   localparam int CLK_PERIOD_NS = 40;
   localparam int STEP0_NS = 62500;
   localparam int STEP1_NS = 31200;
   localparam int STEP2_NS = 15600;
   localparam int STEP3_NS = 7800;
   typedef logic [10:0] tick_t;
   localparam tick_t STEP0_CYC = tick_t'(STEP0_NS / CLK_PERIOD_NS);
   localparam tick_t STEP1_CYC = tick_t'(STEP1_NS / CLK_PERIOD_NS);
   localparam tick_t STEP2_CYC = tick_t'(STEP2_NS / CLK_PERIOD_NS);
   localparam tick_t STEP3_CYC = tick_t'(STEP3_NS / CLK_PERIOD_NS);
   localparam tick_t TICK_RESET = 11'h000;
   typedef logic [12:0] mv_t;
   localparam mv_t ADJ_MV = 13'd800;
   localparam mv_t CH3_BASE_MV = 13'd1100;
   localparam mv_t CH3_STEP_MV = 13'd100;
   localparam mv_t CH2_BASE_MV = 13'd3300;
   localparam mv_t CH2_STEP_MV = 13'd300;
   localparam mv_t CH2_GAP_MV = 13'd4800;
   localparam mv_t CH2_TOP_MV = 13'd5000;
   localparam mv_t CH4_BASE_MV = 13'd2400;
   localparam mv_t CH4_STEP_MV = 13'd100;
   localparam mv_t MV_RESET = 13'd0;
   localparam logic [2:0] CH2_GAP_CODE = 3'b110;
   localparam logic [2:0] CH2_TOP_CODE = 3'b111;
   localparam logic [10:0] FUSE_RESET = 11'h000;
   typedef enum logic [3:0] {
      ST_SYNC = 4'b0001,
      ST_SETTLE = 4'b0010,
      ST_LOAD = 4'b0100,
      ST_RUN = 4'b1000
   } init_state_t;
endpackage
